// *** hdl/odc_map.vh ***
// Register map, field positions, reset values and keys of the oscillator divider control
`ifndef ODC_MAP_VH
`define ODC_MAP_VH

`define ODC_ADDR_OSC_CTRL   12'h000
`define ODC_ADDR_UNLOCK     12'h004
`define ODC_ADDR_INT_STATUS 12'h008
`define ODC_ADDR_INT_MASK   12'h00c

`define ODC_UNLOCK_KEY0     32'haa996655
`define ODC_UNLOCK_KEY1     32'h556699aa

`define ODC_PLLDIV_HI       29
`define ODC_PLLDIV_LO       27
`define ODC_RCDIV_HI        26
`define ODC_RCDIV_LO        24
`define ODC_SOSC_RDY_BIT    22
`define ODC_PBRDY_BIT       21
`define ODC_PB_DIV_HI       20
`define ODC_PB_DIV_LO       19
`define ODC_PLL_MUL_HI      18
`define ODC_PLL_MUL_LO      16
`define ODC_CUR_OSC_HI      14
`define ODC_CUR_OSC_LO      12
`define ODC_NEW_OSC_HI      10
`define ODC_NEW_OSC_LO      8
`define ODC_CLKLOCK_BIT     7
`define ODC_USB_LOCK_BIT    6
`define ODC_SLOCK_BIT       5
`define ODC_SLPEN_BIT       4
`define ODC_CF_BIT          3
`define ODC_USB_RC_BIT      2
`define ODC_SOSC_EN_BIT     1
`define ODC_OSWEN_BIT       0

`define ODC_RCDIV_RESET     3'h1
`define ODC_PB_DIV_RESET    2'h3

`define ODC_INT_SOSC_READY  0
`define ODC_INT_SWITCH_DONE 1
`define ODC_INT_LOCKED_WR   2
`define ODC_INT_PB_DIV_REJ  3
`define ODC_INT_WIDTH       4

`endif

// *** hdl/odc_clk_div.v ***
// Power-of-two divider that emits one tick every N source ticks
`timescale 1ns/1ns
`default_nettype none
module odc_clk_div (
    input  wire       sys_clk,
    input  wire       resetn,
    input  wire       srcTick,
    input  wire [2:0] ratio,
    output reg        outTick,
    output wire       busy
);
    reg [2:0] activeRatio_q;
    reg [7:0] count_q;

    // Codes 000..111 select 1,2,4,8,16,32,64,256
    function [7:0] lastCount;
        input [2:0] code;
        begin
            case (code)
                3'h0:    lastCount = 8'h00;
                3'h1:    lastCount = 8'h01;
                3'h2:    lastCount = 8'h03;
                3'h3:    lastCount = 8'h07;
                3'h4:    lastCount = 8'h0f;
                3'h5:    lastCount = 8'h1f;
                3'h6:    lastCount = 8'h3f;
                default: lastCount = 8'hff;
            endcase
        end
    endfunction

    // A new ratio takes over only at a period boundary so no runt pulse is produced
    assign busy = (ratio != activeRatio_q);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            activeRatio_q <= 3'h0;
            count_q       <= 8'h00;
            outTick       <= 1'b0;
        end else begin
            outTick <= 1'b0;
            if (srcTick) begin
                if (count_q >= lastCount(activeRatio_q)) begin
                    count_q       <= 8'h00;
                    outTick       <= 1'b1;
                    activeRatio_q <= ratio;
                end else begin
                    count_q <= count_q + 8'h01;
                end
            end
        end
    end
endmodule // odc_clk_div
`default_nettype wire

// *** hdl/odc_unlock.v ***
// Two-key unlock sequencer that opens the control register for a single write
`timescale 1ns/1ns
`default_nettype none
`include "odc_map.vh"
module odc_unlock (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        keyWrite,
    input  wire [31:0] keyData,
    input  wire        consume,
    output wire        unlocked
);
    localparam [1:0] ST_LOCKED = 2'h0;
    localparam [1:0] ST_HALF   = 2'h1;
    localparam [1:0] ST_OPEN   = 2'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;

    assign unlocked = (state_q == ST_OPEN);

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_LOCKED: begin
                if (keyWrite && keyData == `ODC_UNLOCK_KEY0)
                    state_d = ST_HALF;
            end
            ST_HALF: begin
                if (keyWrite)
                    state_d = (keyData == `ODC_UNLOCK_KEY1) ? ST_OPEN : ST_LOCKED;
                else if (consume)
                    state_d = ST_LOCKED;
            end
            ST_OPEN: begin
                // Any access except a read of the unlock register closes the window again
                if (consume || keyWrite)
                    state_d = ST_LOCKED;
            end
            default: state_d = ST_LOCKED;
        endcase
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            state_q <= ST_LOCKED;
        else
            state_q <= state_d;
    end
endmodule // odc_unlock
`default_nettype wire

// *** hdl/odc_top.v ***
// Oscillator divider control: APB registers, unlock guard, dividers and interrupt
`timescale 1ns/1ns
`default_nettype none
`include "odc_map.vh"
module odc_top #(
    parameter HAS_USB = 1
) (
    input  wire        sys_clk,
    input  wire        resetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    output reg         irq,
    input  wire [2:0]  cfgPllOutputDivider,
    input  wire [2:0]  cfgPllMultiplier,
    input  wire [1:0]  cfgPeriphBusDivisor,
    input  wire [2:0]  cfgNewOscSelect,
    input  wire        cfgSecondaryOscEnable,
    input  wire        pllTick,
    input  wire        rcTick,
    input  wire        secondaryOscStable,
    input  wire        pllLocked,
    input  wire        usbClockLocked,
    input  wire        clockFail,
    output wire        pllDivTick,
    output wire        rcDivTick,
    output wire        periphClkTick,
    output reg  [2:0]  currentOscSelect,
    output reg  [2:0]  pllMultiplierSel,
    output reg         secondaryOscEnable,
    output reg         sleepEnable,
    output reg         usbRcEnable
);
    reg        cfgLoaded_q;
    reg [2:0]  pllOutDiv_q;
    reg [2:0]  rcDiv_q;
    reg [1:0]  periph_bus_divisor_q;
    reg [2:0]  newOsc_q;
    reg        clkLock_q;
    reg        clkFail_q;
    reg        oscSwitch_q;
    reg        soscStable_q;
    reg        soscReady_q;
    reg        pllLocked_q;
    reg        usbLocked_q;
    reg [`ODC_INT_WIDTH-1:0] intStatus_q;
    reg [`ODC_INT_WIDTH-1:0] intStatus_d;
    reg [`ODC_INT_WIDTH-1:0] intMask_q;
    reg [31:0] readData;
    reg        addrHit;

    wire       pbBusy;
    wire       unlocked;
    wire       pbDivReady = !pbBusy;
    wire       setup      = psel && !penable;
    wire       access     = psel && penable && pready;
    wire       wrTake     = access && pwrite;
    wire       rdTake     = access && !pwrite;
    wire       ctrlSel    = (paddr == `ODC_ADDR_OSC_CTRL);
    wire       keySel     = (paddr == `ODC_ADDR_UNLOCK);
    wire       ctrlWr     = wrTake && ctrlSel && !pslverr;
    wire       ctrlWrOk   = ctrlWr && unlocked;
    wire       pbDivWrite = ctrlWrOk && (pwdata[`ODC_PB_DIV_HI:`ODC_PB_DIV_LO] != periph_bus_divisor_q);
    wire       soscReadyNow = soscStable_q && secondaryOscEnable;

    odc_unlock u_unlock (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .keyWrite (wrTake && keySel),
        .keyData  (pwdata),
        .consume  (access && !keySel),
        .unlocked (unlocked)
    );

    odc_clk_div u_pll_div (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .srcTick (pllTick),
        .ratio   (pllOutDiv_q),
        .outTick (pllDivTick),
        .busy    ()
    );

    odc_clk_div u_rc_div (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .srcTick (rcTick),
        .ratio   (rcDiv_q),
        .outTick (rcDivTick),
        .busy    ()
    );

    // System clock runs every cycle, so the source tick is always high
    odc_clk_div u_pb_div (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .srcTick (1'b1),
        .ratio   ({1'b0, periph_bus_divisor_q}),
        .outTick (periphClkTick),
        .busy    (pbBusy)
    );

    always @* begin
        readData = 32'h0000_0000;
        addrHit  = 1'b1;
        case (paddr)
            `ODC_ADDR_OSC_CTRL: begin
                readData[`ODC_PLLDIV_HI:`ODC_PLLDIV_LO]   = pllOutDiv_q;
                readData[`ODC_RCDIV_HI:`ODC_RCDIV_LO]     = rcDiv_q;
                readData[`ODC_SOSC_RDY_BIT]               = soscReady_q;
                readData[`ODC_PBRDY_BIT]                  = pbDivReady;
                readData[`ODC_PB_DIV_HI:`ODC_PB_DIV_LO]   = periph_bus_divisor_q;
                readData[`ODC_PLL_MUL_HI:`ODC_PLL_MUL_LO] = pllMultiplierSel;
                readData[`ODC_CUR_OSC_HI:`ODC_CUR_OSC_LO] = currentOscSelect;
                readData[`ODC_NEW_OSC_HI:`ODC_NEW_OSC_LO] = newOsc_q;
                readData[`ODC_CLKLOCK_BIT]                = clkLock_q;
                readData[`ODC_USB_LOCK_BIT]               = usbLocked_q;
                readData[`ODC_SLOCK_BIT]                  = pllLocked_q;
                readData[`ODC_SLPEN_BIT]                  = sleepEnable;
                readData[`ODC_CF_BIT]                     = clkFail_q;
                readData[`ODC_USB_RC_BIT]                 = usbRcEnable;
                readData[`ODC_SOSC_EN_BIT]                = secondaryOscEnable;
                readData[`ODC_OSWEN_BIT]                  = oscSwitch_q;
            end
            `ODC_ADDR_UNLOCK:     readData = {31'h0000_0000, unlocked};
            `ODC_ADDR_INT_STATUS: readData[`ODC_INT_WIDTH-1:0] = intStatus_q;
            `ODC_ADDR_INT_MASK:   readData[`ODC_INT_WIDTH-1:0] = intMask_q;
            default:              addrHit = 1'b0;
        endcase
    end

    // Events set sticky bits; a set in the clearing cycle survives the read
    always @* begin
        intStatus_d = intStatus_q;
        if (rdTake && paddr == `ODC_ADDR_INT_STATUS)
            intStatus_d = {`ODC_INT_WIDTH{1'b0}};
        if (soscReadyNow && !soscReady_q)
            intStatus_d[`ODC_INT_SOSC_READY] = 1'b1;
        if (oscSwitch_q)
            intStatus_d[`ODC_INT_SWITCH_DONE] = 1'b1;
        if (ctrlWr && !unlocked)
            intStatus_d[`ODC_INT_LOCKED_WR] = 1'b1;
        if (pbDivWrite && !pbDivReady)
            intStatus_d[`ODC_INT_PB_DIV_REJ] = 1'b1;
    end

    // Bus answer: one wait state; held off until the configuration has loaded
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            irq     <= 1'b0;
        end else begin
            pready <= psel && penable && !pready && cfgLoaded_q;
            if (psel && penable && !pready && cfgLoaded_q) begin
                pslverr <= !addrHit;
                prdata  <= (pwrite || !addrHit) ? 32'h0000_0000 : readData;
            end else if (setup || pready) begin
                pslverr <= 1'b0;
                prdata  <= 32'h0000_0000;
            end
            irq <= |(intStatus_d & intMask_q);
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            intStatus_q  <= {`ODC_INT_WIDTH{1'b0}};
            intMask_q    <= {`ODC_INT_WIDTH{1'b0}};
            soscStable_q <= 1'b0;
            soscReady_q  <= 1'b0;
            pllLocked_q  <= 1'b0;
            usbLocked_q  <= 1'b0;
        end else begin
            intStatus_q  <= intStatus_d;
            soscStable_q <= secondaryOscStable;
            soscReady_q  <= soscReadyNow;
            pllLocked_q  <= pllLocked;
            usbLocked_q  <= (HAS_USB != 0) && usbClockLocked;
            if (wrTake && paddr == `ODC_ADDR_INT_MASK)
                intMask_q <= pwdata[`ODC_INT_WIDTH-1:0];
        end
    end

    // Straps cannot feed an async reset, so they load on the first edge after release
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfgLoaded_q        <= 1'b0;
            pllOutDiv_q        <= 3'h0;
            rcDiv_q            <= `ODC_RCDIV_RESET;
            periph_bus_divisor_q            <= `ODC_PB_DIV_RESET;
            pllMultiplierSel   <= 3'h0;
            newOsc_q           <= 3'h0;
            currentOscSelect   <= 3'h0;
            secondaryOscEnable <= 1'b0;
            clkLock_q          <= 1'b0;
            clkFail_q          <= 1'b0;
            oscSwitch_q        <= 1'b0;
            sleepEnable        <= 1'b0;
            usbRcEnable        <= 1'b0;
        end else if (!cfgLoaded_q) begin
            cfgLoaded_q        <= 1'b1;
            pllOutDiv_q        <= cfgPllOutputDivider;
            pllMultiplierSel   <= cfgPllMultiplier;
            periph_bus_divisor_q            <= cfgPeriphBusDivisor;
            newOsc_q           <= cfgNewOscSelect;
            currentOscSelect   <= cfgNewOscSelect;
            secondaryOscEnable <= cfgSecondaryOscEnable;
        end else begin
            // Switch request completes one cycle after it is raised
            if (oscSwitch_q) begin
                currentOscSelect <= newOsc_q;
                oscSwitch_q      <= 1'b0;
            end
            if (ctrlWrOk) begin
                pllOutDiv_q        <= pwdata[`ODC_PLLDIV_HI:`ODC_PLLDIV_LO];
                rcDiv_q            <= pwdata[`ODC_RCDIV_HI:`ODC_RCDIV_LO];
                pllMultiplierSel   <= pwdata[`ODC_PLL_MUL_HI:`ODC_PLL_MUL_LO];
                sleepEnable        <= pwdata[`ODC_SLPEN_BIT];
                secondaryOscEnable <= pwdata[`ODC_SOSC_EN_BIT];
                usbRcEnable        <= (HAS_USB != 0) && pwdata[`ODC_USB_RC_BIT];
                // The lock bit is one-way until reset and freezes the switch controls
                if (pwdata[`ODC_CLKLOCK_BIT])
                    clkLock_q <= 1'b1;
                if (!clkLock_q) begin
                    newOsc_q <= pwdata[`ODC_NEW_OSC_HI:`ODC_NEW_OSC_LO];
                    if (pwdata[`ODC_OSWEN_BIT])
                        oscSwitch_q <= 1'b1;
                end
                if (pbDivReady)
                    periph_bus_divisor_q <= pwdata[`ODC_PB_DIV_HI:`ODC_PB_DIV_LO];
            end
            // Hardware fail detect wins over a software clear in the same cycle
            if (clockFail)
                clkFail_q <= 1'b1;
            else if (ctrlWrOk)
                clkFail_q <= pwdata[`ODC_CF_BIT];
        end
    end
endmodule // odc_top
`default_nettype wire

// *** testbench/odc_top_chk.sv ***
// Port-level checker for the oscillator divider control block
`timescale 1ns/1ns
`default_nettype none
module odc_top_chk #(
    parameter HAS_USB = 1
) (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [11:0] paddr,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pllTick,
    input wire logic        rcTick,
    input wire logic        pllDivTick,
    input wire logic        rcDivTick,
    input wire logic        periphClkTick,
    input wire logic        secondaryOscStable,
    input wire logic        usbClockLocked
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [3:0] gap_q;
    logic       seen_q;
    wire        rdCtl = pready && !pwrite && paddr == 12'h000;
    // Saturates so a stalled bus clock shows up as an illegal gap, not a wrap
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap_q  <= 4'h0;
            seen_q <= 1'b0;
        end else begin
            gap_q  <= periphClkTick ? 4'h1 : (gap_q == 4'hf ? gap_q : gap_q + 4'h1);
            seen_q <= seen_q | periphClkTick;
        end
    end
    a_reserved_zero: assert property (
        rdCtl |-> prdata[31:30] == 2'h0 && !prdata[23]) else $error("reserved bits set");
    a_sosc_low: assert property (
        rdCtl && !$past(secondaryOscStable, 2) && !$past(secondaryOscStable, 3) |-> !prdata[22])
        else $error("ready bit without stable oscillator");
    a_pll_src: assert property (
        pllDivTick |-> $past(pllTick)) else $error("pll tick without source");
    a_rc_src: assert property (
        rcDivTick |-> $past(rcTick)) else $error("rc tick without source");
    a_peripheral_bus_clock_gap: assert property (
        periphClkTick && seen_q |-> gap_q inside {4'h1, 4'h2, 4'h4, 4'h8})
        else $error("bus clock period illegal");
    a_usb_mirror: assert property (
        rdCtl && $past(usbClockLocked, 2) && $past(usbClockLocked, 3) |->
        prdata[6] == (HAS_USB != 0)) else $error("usb lock bit wrong");
    a_err_zero: assert property (
        pslverr |-> pready && prdata == 32'h0) else $error("error with data");
    a_unmapped_err: assert property (
        pready && paddr[11:4] != 8'h0 |-> pslverr) else $error("unmapped without error");
    c_sosc_read: cover property (rdCtl && prdata[22]);
    c_unmapped: cover property (pslverr);
    c_bus_div1: cover property (periphClkTick && gap_q == 4'h1);
endmodule // odc_top_chk
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the oscillator divider control block
`timescale 1ns/1ns
`default_nettype none
`include "odc_map.vh"
module testbench;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         irq;
    wire         pllDivTick;
    wire         rcDivTick;
    wire         periphClkTick;
    logic        pllTick = 1'b0;
    logic        rcTick = 1'b0;
    logic        secondaryOscStable = 1'b0;
    logic [2:0]  cfgPod = 3'h5;
    logic [2:0]  cfgMul = 3'h2;
    logic [1:0]  cfgPbd = 2'h2;
    logic [2:0]  cfgNos = 3'h3;
    logic        cfgSen = 1'b1;
    logic        usbLock = 1'b1;
    wire  [2:0]  curOsc;
    wire  [2:0]  mulSel;
    wire         secondary_osc_enable;
    wire         sleepEn;
    wire         usbRcEn;
    logic [31:0] rd;
    logic        er;
    int          bad_count = 0;
    int          comparisons = 0;

    odc_top #(.HAS_USB(1)) i_odc_top (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .cfgPllOutputDivider(cfgPod), .cfgPllMultiplier(cfgMul),
        .cfgPeriphBusDivisor(cfgPbd), .cfgNewOscSelect(cfgNos), .cfgSecondaryOscEnable(cfgSen),
        .pllTick(pllTick), .rcTick(rcTick), .secondaryOscStable(secondaryOscStable),
        .pllLocked(1'b1), .usbClockLocked(usbLock), .clockFail(1'b0), .pllDivTick(pllDivTick),
        .rcDivTick(rcDivTick), .periphClkTick(periphClkTick), .currentOscSelect(curOsc),
        .pllMultiplierSel(mulSel), .secondaryOscEnable(secondary_osc_enable), .sleepEnable(sleepEn),
        .usbRcEnable(usbRcEn));

    always #5 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Read right after the edge: these are the values the master samples there
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) chk(32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] val(input logic [2:0] p, input logic [2:0] r,
                                        input logic s, input logic y, input logic [1:0] b);
        return {2'h0, p, r, 1'b0, s, y, b, 3'h2, 8'h33, 8'h02};
    endfunction

    task automatic wrc(input logic [31:0] d);
        apb(1'b1, `ODC_ADDR_UNLOCK, `ODC_UNLOCK_KEY0);
        apb(1'b1, `ODC_ADDR_UNLOCK, `ODC_UNLOCK_KEY1);
        apb(1'b1, `ODC_ADDR_OSC_CTRL, d);
    endtask

    task automatic s_reset();
        apb(1'b0, `ODC_ADDR_OSC_CTRL, 32'h0);
        chk(rd & 32'hffffff03, val(3'h5, 3'h1, 1'b0, 1'b1, 2'h2));
        chk({29'h0, rd[26:24]}, 32'h1);
        chk(rd & 32'hc0800000, 32'h0);
        chk({31'h0, rd[6]}, 32'h1);
        chk({29'h0, curOsc}, 32'h3);
        chk({29'h0, mulSel}, 32'h2);
        chk({31'h0, secondary_osc_enable}, 32'h1);
        chk({30'h0, sleepEn, usbRcEn}, 32'h0);
    endtask

    task automatic s_lock();
        usbLock <= 1'b0;
        apb(1'b1, `ODC_ADDR_OSC_CTRL, val(3'h0, 3'h0, 1'b0, 1'b0, 2'h2));
        apb(1'b0, `ODC_ADDR_OSC_CTRL, 32'h0);
        chk({29'h0, rd[29:27]}, 32'h5);
        wrc(val(3'h0, 3'h0, 1'b0, 1'b0, 2'h2) | 32'hc0800004);
        apb(1'b0, `ODC_ADDR_OSC_CTRL, 32'h0);
        chk(rd & 32'hffdfff03, val(3'h0, 3'h0, 1'b0, 1'b0, 2'h2));
        chk({30'h0, rd[6], usbRcEn}, 32'h1);
        usbLock <= 1'b1;
        apb(1'b0, 12'h010, 32'h0);
        chk({rd[30:0], er}, 32'h1);
    endtask

    task automatic s_div();
        int pc;
        int rc;
        int bc;
        for (int c = 0; c < 8; c++) begin
            wrc(val(c[2:0], c[2:0], 1'b0, 1'b0, c[1:0]));
            pllTick <= 1'b1;
            rcTick <= 1'b1;
            // Long settle so the slowest ratio has passed a period boundary
            repeat (600) @(posedge sys_clk);
            pc = 0;
            rc = 0;
            bc = 0;
            repeat (512) begin
                @(posedge sys_clk);
                #1;
                pc += pllDivTick;
                rc += rcDivTick;
                bc += periphClkTick;
            end
            chk(pc, 512 >> (c == 7 ? 8 : c));
            chk(rc, 512 >> (c == 7 ? 8 : c));
            chk(bc, 512 >> c[1:0]);
            @(posedge sys_clk);
            pllTick <= 1'b0;
            rcTick <= 1'b0;
        end
    endtask

    task automatic s_ready();
        apb(1'b1, `ODC_ADDR_UNLOCK, `ODC_UNLOCK_KEY0);
        apb(1'b1, `ODC_ADDR_UNLOCK, `ODC_UNLOCK_KEY1);
        // Align to a bus clock tick so the new divisor is still pending at the read
        repeat (9) begin
            @(posedge sys_clk);
            #1;
            if (periphClkTick === 1'b1) break;
        end
        apb(1'b1, `ODC_ADDR_OSC_CTRL, val(3'h7, 3'h7, 1'b0, 1'b0, 2'h0));
        apb(1'b0, `ODC_ADDR_OSC_CTRL, 32'h0);
        chk({31'h0, rd[21]}, 32'h0);
        repeat (10) @(posedge sys_clk);
        apb(1'b0, `ODC_ADDR_OSC_CTRL, 32'h0);
        chk({29'h0, rd[21:19]}, 32'h4);
    endtask

    task automatic s_switch();
        // Switch to source 5 with sleep set, then lock and try to move away
        wrc(val(3'h7, 3'h7, 1'b0, 1'b0, 2'h0) & 32'hfffff800 | 32'h00000513);
        apb(1'b0, `ODC_ADDR_OSC_CTRL, 32'h0);
        chk({16'h0, rd[15:0]}, 32'h5572);
        chk({28'h0, sleepEn, curOsc}, 32'hd);
        wrc(val(3'h7, 3'h7, 1'b0, 1'b0, 2'h0) & 32'hfffff800 | 32'h00000592);
        wrc(val(3'h7, 3'h7, 1'b0, 1'b0, 2'h0) & 32'hfffff800 | 32'h00000113);
        apb(1'b0, `ODC_ADDR_OSC_CTRL, 32'h0);
        chk({16'h0, rd[15:0]}, 32'h55f2);
    endtask

    task automatic s_irq();
        apb(1'b1, `ODC_ADDR_INT_MASK, 32'h0);
        secondaryOscStable <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, `ODC_ADDR_OSC_CTRL, 32'h0);
        chk({31'h0, rd[22]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `ODC_ADDR_INT_MASK, 32'hf);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({31'h0, irq}, 32'h1);
        apb(1'b0, `ODC_ADDR_INT_STATUS, 32'h0);
        chk(rd & 32'h5, 32'h5);
        repeat (2) @(posedge sys_clk);
        #1;
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        // Strap load retargets the bus divisor; its ready bit settles at the next boundary
        repeat (12) @(posedge sys_clk);
        s_reset();
        s_lock();
        s_div();
        s_ready();
        s_switch();
        s_irq();
        give_verdict();
    end

    initial begin
        #400000;
        bad_count++;
        give_verdict();
    end
endmodule // testbench

bind odc_top odc_top_chk #(.HAS_USB(HAS_USB)) i_odc_top_chk (
    .sys_clk(sys_clk), .resetn(resetn), .paddr(paddr), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pllTick(pllTick), .rcTick(rcTick),
    .pllDivTick(pllDivTick), .rcDivTick(rcDivTick), .periphClkTick(periphClkTick),
    .secondaryOscStable(secondaryOscStable), .usbClockLocked(usbClockLocked));
`default_nettype wire
